// [hdl/vsp_pkg.sv]
// Constants and types for the valley switching gate timing core
package vsp_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int CNT_W = 16;

  localparam int VALLEY_DELAY_NS = 500;
  localparam int MASK_NS = 2000;
  localparam int SMIN_NS = 8500;
  localparam int EXTRA_NS = 5000;
  localparam int START_NS = 130000;
  localparam int ON_TIME_NS = 5000;
  localparam int KNEE_NS = 1000;
  localparam int RESTART_NS = 1000000;

  localparam logic [CNT_W-1:0] VALLEY_DELAY_CYC =
    CNT_W'((VALLEY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] MASK_CYC =
    CNT_W'((MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SMIN_CYC =
    CNT_W'((SMIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] SMIN_EXTRA_CYC =
    CNT_W'((SMIN_NS + EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] START_CYC =
    CNT_W'((START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ON_TIME_CYC =
    CNT_W'((ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] KNEE_CYC =
    CNT_W'((KNEE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int RESTART_CYC = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic RST_GATE = 1'h0;
  localparam logic RST_ENABLED = 1'h0;
  localparam logic RST_FAULT = 1'h0;

  // Comparator outputs from the analog front end
  typedef struct packed {
    logic supply_off;
    logic supply_on;
    logic overvoltage;
    logic arm;
    logic detect;
  } vsp_sense_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ON = 2'h1,
    ST_WAIT = 2'h3,
    ST_FAULT = 2'h2
  } vsp_state_t;

endpackage

// [hdl/vsp_timing.sv]
// Valley switching gate timing core with output overvoltage restart
//
// How it works
// [RULE1] A valley pulse follows a falling detect crossing after a fixed delay.
// [RULE2] A crossing gives a pulse only if the sense passed the arm level earlier in that ring.
// [RULE3] A falling crossing no later than the end of the mask interval is ignored.
// [RULE4] With no usable valley the starter interval from the last gate rise starts a pulse.
// [RULE5] During the minimum period after a gate rise no valley may start a gate pulse.
// [RULE6] After the minimum period the first valley pulse starts the next gate pulse.
// [RULE7] Valleys inside the minimum period force a pulse at minimum period plus extra delay.
// [RULE8] A sampled sense above the overvoltage level raises the fault and holds the gate low.
// [RULE9] After an overvoltage stop the core restarts and trips again if the fault persists.
// [RULE10] The core enables above the rising lockout level and disables below the falling one.
// [RULE11] Each gate pulse lasts a fixed on-time with no current based early end.
// [RULE12] The overvoltage comparison is sampled at the knee point after the gate falls.
// [RULE13] The mask starts at the gate fall and all timers count the internal clock.
// [RULE14] While locked out all timers are cleared, while faulted all but the restart timer are, and the gate is held low.

`timescale 1ns/1ps

module vsp_timing #(
  parameter int RESTART_CYCLES = vsp_pkg::RESTART_CYC
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire vsp_pkg::vsp_sense_t SENSE_IN,
  output logic GATE_DRIVE_OUT,
  output logic VALLEY_PULSE_OUT,
  output logic OVP_FAULT_OUT,
  output logic ENABLED_OUT
);

  localparam int CW = vsp_pkg::CNT_W;
  // The restart wait must fit the timer width; longer waits need a wider CNT_W
  localparam logic [CW-1:0] RESTART_LIM = CW'(RESTART_CYCLES);

  vsp_pkg::vsp_sense_t sense_meta;
  vsp_pkg::vsp_sense_t sense_sync;
  logic detect_prev;
  logic fall_cross;

  vsp_pkg::vsp_state_t state;
  vsp_pkg::vsp_state_t next_state;

  logic enabled;
  logic fault;
  logic run;
  logic start;
  logic trigger;

  logic [CW-1:0] period_cnt;
  logic [CW-1:0] on_cnt;
  logic [CW-1:0] fall_cnt;
  logic [CW-1:0] dly_cnt;
  logic [CW-1:0] restart_cnt;

  logic armed;
  logic dly_active;
  logic valley_now;
  logic seen;
  logic mask_over;
  logic smin_over;
  logic knee_hit;

  // True once a counter has reached its limit
  function automatic logic reached(
    input logic [CW-1:0] cnt,
    input logic [CW-1:0] lim
  );
    reached = (cnt >= lim);
  endfunction

  // Comparator outputs are asynchronous to the timer clock
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sense_meta <= '0;
      sense_sync <= '0;
    end else begin
      sense_meta <= SENSE_IN;
      sense_sync <= sense_meta;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      detect_prev <= 1'h0;
    end else begin
      detect_prev <= sense_sync.detect;
    end
  end

  // Detect goes high when the sense drops below its threshold
  // Previous value resets low, the idle level of the comparator, so no false edge
  assign fall_cross = sense_sync.detect & ~detect_prev;

  // Falling level wins so a sagging supply always shuts down
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      enabled <= vsp_pkg::RST_ENABLED;
    end else if (sense_sync.supply_off) begin
      enabled <= 1'h0; // [RULE10]
    end else if (sense_sync.supply_on) begin
      enabled <= 1'h1; // [RULE10]
    end
  end

  assign run = enabled & ~fault;

  assign mask_over = fall_cnt > vsp_pkg::MASK_CYC;
  // A valley at the last count of the minimum period may already start a pulse
  assign smin_over = reached(period_cnt, vsp_pkg::SMIN_CYC - 16'h0001);
  assign knee_hit = (state == vsp_pkg::ST_WAIT) && (fall_cnt == vsp_pkg::KNEE_CYC);
  assign valley_now = dly_active && reached(dly_cnt, vsp_pkg::VALLEY_DELAY_CYC);

  // Limits sit one count short: the gate rises on the edge after the trigger,
  // so the period from rise to rise equals the interval itself
  always_comb begin
    trigger = 1'h0;
    if (valley_now && smin_over) begin
      trigger = 1'h1; // [RULE6]
    end
    if (seen && reached(period_cnt, vsp_pkg::SMIN_EXTRA_CYC - 16'h0001)) begin
      trigger = 1'h1; // [RULE7]
    end
    if (reached(period_cnt, vsp_pkg::START_CYC - 16'h0001)) begin
      trigger = 1'h1; // [RULE4]
    end
  end

  // Lockout overrides every state so the gate cannot rise on a sagging supply
  always_comb begin
    next_state = state;
    start = 1'h0;
    case (state)
      vsp_pkg::ST_IDLE: begin
        if (run) begin
          next_state = vsp_pkg::ST_ON;
          start = 1'h1;
        end
      end
      vsp_pkg::ST_ON: begin
        if (reached(on_cnt, vsp_pkg::ON_TIME_CYC - 16'h0001)) begin
          next_state = vsp_pkg::ST_WAIT; // [RULE11]
        end
      end
      vsp_pkg::ST_WAIT: begin
        if (knee_hit && sense_sync.overvoltage) begin
          next_state = vsp_pkg::ST_FAULT; // [RULE8]
        end else if (trigger) begin
          next_state = vsp_pkg::ST_ON;
          start = 1'h1;
        end
      end
      vsp_pkg::ST_FAULT: begin
        if (!fault) begin
          next_state = vsp_pkg::ST_IDLE; // [RULE9]
        end
      end
      default: begin
        next_state = vsp_pkg::ST_IDLE;
      end
    endcase
    if (!enabled) begin
      next_state = vsp_pkg::ST_IDLE; // [RULE14]
      start = 1'h0;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state <= vsp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      GATE_DRIVE_OUT <= vsp_pkg::RST_GATE;
    end else begin
      // Follows the next state so the gate rises on the same edge as the valley pulse
      GATE_DRIVE_OUT <= (next_state == vsp_pkg::ST_ON); // [RULE8] [RULE14]
    end
  end

  // Period timer runs from each gate rise and saturates at the starter limit
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      period_cnt <= '0;
    end else if (!run) begin
      period_cnt <= '0; // [RULE14]
    end else if (start) begin
      period_cnt <= '0; // [RULE13]
    end else if (!reached(period_cnt, vsp_pkg::START_CYC)) begin
      period_cnt <= period_cnt + 16'h0001;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      on_cnt <= '0;
    end else if (state == vsp_pkg::ST_ON && run) begin
      // Only the count or a lockout ends the pulse; no current sense can cut it short
      on_cnt <= on_cnt + 16'h0001; // [RULE11]
    end else begin
      on_cnt <= '0;
    end
  end

  // Time since the gate fell; feeds both the mask and the knee sample
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fall_cnt <= '0;
    end else if (state != vsp_pkg::ST_WAIT || !run) begin
      fall_cnt <= '0; // [RULE13]
    end else if (!mask_over || fall_cnt <= vsp_pkg::KNEE_CYC) begin
      fall_cnt <= fall_cnt + 16'h0001;
    end
  end

  // Arming is per ring: every falling crossing consumes it
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      armed <= 1'h0;
    end else if (state != vsp_pkg::ST_WAIT || !run) begin
      armed <= 1'h0;
    end else if (fall_cross) begin
      armed <= 1'h0; // [RULE2]
    end else if (sense_sync.arm) begin
      armed <= 1'h1; // [RULE2]
    end
  end

  // A new qualified crossing restarts the delay of a pending one
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dly_active <= 1'h0;
      dly_cnt <= '0;
    end else if (state != vsp_pkg::ST_WAIT || !run) begin
      dly_active <= 1'h0;
      dly_cnt <= '0;
    end else if (fall_cross && armed && mask_over) begin
      dly_active <= 1'h1; // [RULE1] [RULE3]
      dly_cnt <= 16'h0001;
    end else if (valley_now) begin
      dly_active <= 1'h0;
      dly_cnt <= '0;
    end else if (dly_active) begin
      dly_cnt <= dly_cnt + 16'h0001; // [RULE1]
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      VALLEY_PULSE_OUT <= 1'h0;
    end else begin
      // Shown even when the minimum period blocks it, for outside observation
      VALLEY_PULSE_OUT <= valley_now; // [RULE1]
    end
  end

  // Valleys inside the minimum period only arm the late forced start
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      seen <= 1'h0;
    end else if (start || !run) begin
      seen <= 1'h0;
    end else if (valley_now && !smin_over) begin
      seen <= 1'h1; // [RULE5] [RULE7]
    end
  end

  // Knee sample only; a late rise of the sense is not a fault
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fault <= vsp_pkg::RST_FAULT;
      restart_cnt <= '0;
    end else if (!enabled) begin
      fault <= 1'h0; // [RULE14]
      restart_cnt <= '0;
    end else if (!fault) begin
      restart_cnt <= '0;
      if (knee_hit && sense_sync.overvoltage) begin
        fault <= 1'h1; // [RULE8] [RULE12]
      end
    end else if (reached(restart_cnt, RESTART_LIM - 16'h0001)) begin
      fault <= 1'h0; // [RULE9]
      restart_cnt <= '0;
    end else begin
      restart_cnt <= restart_cnt + 16'h0001; // [RULE9]
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      OVP_FAULT_OUT <= 1'h0;
      ENABLED_OUT <= 1'h0;
    end else begin
      // Masked by lockout so the fault and enable outputs never disagree
      OVP_FAULT_OUT <= fault & enabled; // [RULE14]
      ENABLED_OUT <= enabled;
    end
  end

endmodule

// [verif/vsp_aux_model.sv]
// Auxiliary winding ringing as seen by the sense comparators after each gate fall
`timescale 1ns/1ps
module vsp_aux_model (
  input wire logic clk_in,
  input wire logic gate_in,
  input wire logic [10:0] arm_at_in,
  input wire logic [10:0] det_at_in,
  input wire logic ovp_in,
  output logic arm_out,
  output logic detect_out,
  output logic overvoltage_out
);
  logic [10:0] cnt = 11'h7FF;
  always_ff @(posedge clk_in) begin
    cnt <= gate_in ? 11'h000 : (cnt == 11'h7FF ? cnt : cnt + 11'h001);
  end
  // One ring per off time; arm_at equal to det_at gives a ring that never arms
  assign arm_out = !gate_in && cnt >= arm_at_in && cnt < det_at_in;
  assign detect_out = !gate_in && cnt >= det_at_in && cnt < det_at_in + 11'h008;
  // Output level only shows near the knee, so a late sample would miss it
  assign overvoltage_out = ovp_in && !gate_in && cnt >= 11'h006 && cnt < 11'h00C;
endmodule

// [verif/vsp_timing_props.sv]
// Timing checks on the valley switching gate core ports
`timescale 1ns/1ps
module vsp_timing_props #(
  parameter int RESTART_CYCLES = 20
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire vsp_pkg::vsp_sense_t SENSE_IN,
  input wire logic GATE_DRIVE_OUT,
  input wire logic VALLEY_PULSE_OUT,
  input wire logic OVP_FAULT_OUT,
  input wire logic ENABLED_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic g_q;
  logic seen;
  logic early;
  logic [11:0] per;
  int ov_cnt;
  wire rise = GATE_DRIVE_OUT && !g_q;
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      g_q <= 1'h0;
      per <= 12'h000;
    end else begin
      g_q <= GATE_DRIVE_OUT;
      per <= rise ? 12'h001 : (per == 12'hFFF ? per : per + 12'h001);
    end
  end
  // Period is only meaningful between two rises of one uninterrupted run
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      seen <= 1'h0;
    end else if (!ENABLED_OUT || OVP_FAULT_OUT) begin
      seen <= 1'h0;
    end else if (rise) begin
      seen <= 1'h1;
    end
  end
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      early <= 1'h0;
    end else if (rise || !seen) begin
      early <= 1'h0;
    end else if (VALLEY_PULSE_OUT && per < 12'h055) begin
      early <= 1'h1;
    end
  end
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ov_cnt <= 0;
    end else begin
      ov_cnt <= OVP_FAULT_OUT ? ov_cnt + 1 : 0;
    end
  end
  a_gate_on_time: assert property (
    $rose(GATE_DRIVE_OUT) |-> ##49 GATE_DRIVE_OUT ##1 !GATE_DRIVE_OUT)
    else $error("gate on time wrong");
  a_min_period: assert property (
    rise && seen |-> per >= 12'h055)
    else $error("period below minimum");
  // The gate must already be high on the cycle the starter count is reached
  a_starter_bound: assert property (
    seen && !GATE_DRIVE_OUT |-> per <= 12'h513)
    else $error("starter late");
  a_first_valley: assert property (
    VALLEY_PULSE_OUT && seen && per >= 12'h055 |-> GATE_DRIVE_OUT)
    else $error("valley did not start gate");
  a_extra_delay: assert property (
    early && !GATE_DRIVE_OUT |-> per <= 12'h086)
    else $error("forced trigger late");
  a_valley_width: assert property (
    VALLEY_PULSE_OUT |=> !VALLEY_PULSE_OUT)
    else $error("valley pulse too long");
  a_fault_gate_low: assert property (
    OVP_FAULT_OUT |-> !GATE_DRIVE_OUT)
    else $error("gate high in fault");
  a_lockout_low: assert property (
    !ENABLED_OUT |-> !GATE_DRIVE_OUT && !OVP_FAULT_OUT)
    else $error("active while locked out");
  a_supply_off: assert property (
    SENSE_IN.supply_off [*4] |=> !ENABLED_OUT)
    else $error("not disabled on low supply");
  a_restart_wait: assert property (
    $fell(OVP_FAULT_OUT) && ENABLED_OUT |-> ov_cnt >= RESTART_CYCLES ##[0:2] GATE_DRIVE_OUT)
    else $error("restart wrong");
  c_period: cover property (rise && seen);
  c_fault: cover property ($rose(OVP_FAULT_OUT));
  c_early: cover property (early && rise);
endmodule
bind vsp_timing vsp_timing_props #(.RESTART_CYCLES(RESTART_CYCLES)) u_props (
  .CLOCK_IN(CLOCK_IN),
  .RST_N_IN(RST_N_IN),
  .SENSE_IN(SENSE_IN),
  .GATE_DRIVE_OUT(GATE_DRIVE_OUT),
  .VALLEY_PULSE_OUT(VALLEY_PULSE_OUT),
  .OVP_FAULT_OUT(OVP_FAULT_OUT),
  .ENABLED_OUT(ENABLED_OUT)
);

// [verif/vsp_timing_tb.sv]
// Self-checking bench for the valley switching gate core
`timescale 1ns/1ps
module vsp_timing_tb;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic s_on = 1'h0;
  logic s_off = 1'h0;
  logic ovp_en = 1'h0;
  logic [10:0] arm_at = 11'h005;
  logic [10:0] det_at = 11'h028;
  logic arm, det, ov, gate, valley, fault, en;
  logic [15:0] h, p, v;
  vsp_pkg::vsp_sense_t sense;
  int mismatches = 0;
  int tests_run = 0;
  assign sense = {s_off, s_on, ov, arm, det};
  always #50 clk = ~clk;
  vsp_timing #(.RESTART_CYCLES(20)) uut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .SENSE_IN(sense),
    .GATE_DRIVE_OUT(gate), .VALLEY_PULSE_OUT(valley), .OVP_FAULT_OUT(fault), .ENABLED_OUT(en));
  vsp_aux_model aux (.clk_in(clk), .gate_in(gate), .arm_at_in(arm_at), .det_at_in(det_at),
    .ovp_in(ovp_en), .arm_out(arm), .detect_out(det), .overvoltage_out(ov));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // From one gate rise to the next: high time, period and valley pulses seen
  task automatic measure();
    int n;
    n = 0;
    h = '0;
    p = '0;
    v = '0;
    while (gate !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    while (gate === 1'b1 && p < 3000) begin
      @(negedge clk);
      p++;
      h++;
    end
    while (gate !== 1'b1 && p < 3000) begin
      @(negedge clk);
      p++;
      v += 16'(valley === 1'b1);
    end
  endtask
  task automatic wait_lvl(input logic lvl, input int lim);
    int n;
    n = 0;
    while (fault !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    check(fault, lvl);
  endtask
  // First measure spans the change of ring shape; only the second is judged
  task automatic ring(input logic [10:0] a, input logic [10:0] d);
    @(posedge clk);
    arm_at <= a;
    det_at <= d;
    @(negedge clk);
    measure();
    measure();
  endtask
  task automatic finish_test();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    s_on <= 1'h1;
    repeat (8) @(negedge clk);
    check(en, 1'h1);
    ring(11'h005, 11'h028);
    check(h, 16'h0032);
    check(v, 16'h0001);
    check(p, 16'h0062);
    ring(11'h005, 11'h00F);
    check(v, 16'h0000);
    check(p, 16'h0514);
    ring(11'h028, 11'h028);
    check(v, 16'h0000);
    check(p, 16'h0514);
    ring(11'h005, 11'h016);
    check(p, 16'h0087);
    check(v, 16'h0001);
    @(posedge clk);
    ovp_en <= 1'h1;
    wait_lvl(1'h1, 3000);
    check(gate, 1'h0);
    wait_lvl(1'h0, 100);
    wait_lvl(1'h1, 200);
    @(posedge clk);
    ovp_en <= 1'h0;
    wait_lvl(1'h0, 100);
    measure();
    check(h, 16'h0032);
    // Drop the supply in the off time so no gate pulse is cut short
    while (gate === 1'b1) begin
      @(negedge clk);
    end
    @(posedge clk);
    s_off <= 1'h1;
    repeat (8) @(negedge clk);
    check(en, 1'h0);
    measure();
    check(h, 16'h0000);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule
